// file: core/printer_parallel_port.sv
// Printer parallel port: registers, handshake lines and status
`timescale 1ns/1ps
`default_nettype none
`include "printer_port_params.svh"
module printer_parallel_port (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire printer_port_pkg::bus_req_t busReq,
  output printer_port_pkg::bus_rsp_t busRsp,
  // First port and its handshake pair
  output logic [7:0] firstPortLines,
  output logic [7:0] firstPortLinesOe,
  output logic dataOutStrobe,
  input wire logic ackInStrobe,
  // Second port and its handshake pair
  input wire logic [7:0] secondPortLinesIn,
  output logic [7:0] secondPortLinesOut,
  output logic [7:0] secondPortLinesOe,
  input wire logic faultInLine,
  output logic printerResetN,
  // Printer state
  output logic printerReady
);
  import printer_port_pkg::*;

  function automatic logic hit(input logic [23:0] a, input logic [23:0] target);
    hit = (a == target);
  endfunction

  logic [7:0] genCtrl_q, genCtrl_d;
  logic [7:0] svcReq_q, svcReq_d;
  logic [7:0] firstDir_q, firstDir_d;
  logic [7:0] secondDir_q, secondDir_d;
  logic [7:0] firstCtrl_q, firstCtrl_d;
  logic [7:0] secondCtrl_q, secondCtrl_d;
  logic [7:0] secondData_q, secondData_d;
  logic faultFlag_q, faultFlag_d;
  bus_rsp_t rsp_q, rsp_d;
  logic strobePin_q, strobePin_d;
  logic initPin_q, initPin_d;
  logic ackAsserted_q, faultAsserted_q;
  logic ready_q, ready_d;
  logic ackAsserted, faultAsserted;
  logic ackEvent, faultEvent;
  logic firstEn, secondEn;
  logic wr, rd;
  logic loadValid;
  logic [7:0] lineData;
  logic strobeOn;
  logic canAccept;
  logic bothEmpty;

  // ==========================================
  // Handshake input sensing
  // sense bits set line polarity
  assign ackAsserted = ~(ackInStrobe ^ genCtrl_q[`ACK_SENSE_BIT]);
  assign faultAsserted = ~(faultInLine ^ genCtrl_q[`FAULT_SENSE_BIT]);
  assign firstEn = genCtrl_q[`FIRST_EN_BIT];
  assign secondEn = genCtrl_q[`SECOND_EN_BIT];
  assign ackEvent = firstEn && ackAsserted && !ackAsserted_q;
  assign faultEvent = secondEn && faultAsserted && !faultAsserted_q;
  assign wr = busReq.sel && busReq.write;
  assign rd = busReq.sel && !busReq.write;
  assign loadValid = wr && hit(busReq.addr, `FIRST_DATA_ADDR);

  // ==========================================
  // Output latch
  // first port output data with strobe pair
  output_latch latch (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .enable(firstEn),
    .loadValid(loadValid),
    .loadData(busReq.wdata[7:0]),
    .ackEvent(ackEvent),
    .lineData(lineData),
    .strobeOn(strobeOn),
    .canAccept(canAccept),
    .bothEmpty(bothEmpty)
  );

  // ==========================================
  // Register writes and reads
  always_comb
  begin
    genCtrl_d = genCtrl_q;
    svcReq_d = svcReq_q;
    firstDir_d = firstDir_q;
    secondDir_d = secondDir_q;
    firstCtrl_d = firstCtrl_q;
    secondCtrl_d = secondCtrl_q;
    secondData_d = secondData_q;
    if (wr)
    begin
      if (hit(busReq.addr, `GEN_CTRL_ADDR))
      begin
        genCtrl_d = busReq.wdata[7:0];
      end
      else if (hit(busReq.addr, `SVC_REQ_ADDR))
      begin
        svcReq_d = busReq.wdata[7:0];
      end
      else if (hit(busReq.addr, `FIRST_DIR_ADDR))
      begin
        firstDir_d = busReq.wdata[7:0];
      end
      else if (hit(busReq.addr, `SECOND_DIR_ADDR))
      begin
        secondDir_d = busReq.wdata[7:0];
      end
      else if (hit(busReq.addr, `FIRST_CTRL_ADDR))
      begin
        firstCtrl_d = busReq.wdata[7:0];
      end
      else if (hit(busReq.addr, `SECOND_CTRL_ADDR))
      begin
        secondCtrl_d = busReq.wdata[7:0];
      end
      else if (hit(busReq.addr, `SECOND_DATA_ADDR))
      begin
        secondData_d = busReq.wdata[7:0];
      end
    end
    // Sticky fault flag, set wins over clear
    faultFlag_d = (faultFlag_q && !(wr && hit(busReq.addr, `STATUS_ADDR)
      && busReq.wdata[`FAULT_FLAG_BIT])) || faultEvent;
    rsp_d.ack = busReq.sel;
    rsp_d.rdata = 16'h0000;
    if (rd)
    begin
      if (hit(busReq.addr, `GEN_CTRL_ADDR))
      begin
        rsp_d.rdata[7:0] = genCtrl_q;
      end
      else if (hit(busReq.addr, `SVC_REQ_ADDR))
      begin
        rsp_d.rdata[7:0] = svcReq_q;
      end
      else if (hit(busReq.addr, `FIRST_DIR_ADDR))
      begin
        rsp_d.rdata[7:0] = firstDir_q;
      end
      else if (hit(busReq.addr, `SECOND_DIR_ADDR))
      begin
        rsp_d.rdata[7:0] = secondDir_q;
      end
      else if (hit(busReq.addr, `FIRST_CTRL_ADDR))
      begin
        rsp_d.rdata[7:0] = firstCtrl_q;
      end
      else if (hit(busReq.addr, `SECOND_CTRL_ADDR))
      begin
        rsp_d.rdata[7:0] = secondCtrl_q;
      end
      else if (hit(busReq.addr, `FIRST_DATA_ADDR))
      begin
        rsp_d.rdata[7:0] = lineData;
      end
      else if (hit(busReq.addr, `SECOND_DATA_ADDR))
      begin
        // inputs read pins, outputs read latch
        rsp_d.rdata[7:0] = (secondData_q & secondDir_q) | (secondPortLinesIn & ~secondDir_q);
      end
      else if (hit(busReq.addr, `STATUS_ADDR))
      begin
        rsp_d.rdata[7:0] = {initPin_q, faultInLine, strobePin_q, ackInStrobe,
          1'b0, faultFlag_q, bothEmpty, canAccept};
      end
    end
  end

  // ==========================================
  // Handshake outputs and printer state
  always_comb
  begin
    // bit 3 sets output line level
    strobePin_d = ~((firstEn && (strobeOn || firstCtrl_q[`LEVEL_BIT]))
      ^ genCtrl_q[`STROBE_SENSE_BIT]);
    initPin_d = ~((secondEn && secondCtrl_q[`LEVEL_BIT]) ^ genCtrl_q[`INIT_SENSE_BIT]);
    // not ready on paper out, busy, deselect
    ready_d = secondPortLinesIn[`SELECT_BIT] && !secondPortLinesIn[`PAPER_OUT_BIT]
      && !secondPortLinesIn[`BUSY_BIT];
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      genCtrl_q <= `REG_RESET;
      svcReq_q <= `REG_RESET;
      firstDir_q <= `REG_RESET;
      secondDir_q <= `REG_RESET;
      firstCtrl_q <= `REG_RESET;
      secondCtrl_q <= `REG_RESET;
      secondData_q <= `REG_RESET;
      faultFlag_q <= 1'b0;
      rsp_q <= '0;
      strobePin_q <= `PIN_IDLE;
      initPin_q <= `PIN_IDLE;
      ackAsserted_q <= 1'b0;
      faultAsserted_q <= 1'b0;
      ready_q <= 1'b0;
    end
    else if (ce)
    begin
      genCtrl_q <= genCtrl_d;
      svcReq_q <= svcReq_d;
      firstDir_q <= firstDir_d;
      secondDir_q <= secondDir_d;
      firstCtrl_q <= firstCtrl_d;
      secondCtrl_q <= secondCtrl_d;
      secondData_q <= secondData_d;
      faultFlag_q <= faultFlag_d;
      rsp_q <= rsp_d;
      strobePin_q <= strobePin_d;
      initPin_q <= initPin_d;
      ackAsserted_q <= ackAsserted;
      faultAsserted_q <= faultAsserted;
      ready_q <= ready_d;
    end
  end

  assign busRsp = rsp_q;
  assign firstPortLines = lineData;
  assign firstPortLinesOe = firstDir_q;
  assign secondPortLinesOut = secondData_q;
  assign secondPortLinesOe = secondDir_q;
  assign dataOutStrobe = strobePin_q;
  assign printerResetN = initPin_q;
  assign printerReady = ready_q;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence sStatusRead;
    ce && rd && hit(busReq.addr, `STATUS_ADDR);
  endsequence

  sequence sSecondDirWrite;
    ce && wr && hit(busReq.addr, `SECOND_DIR_ADDR);
  endsequence

  sequence sFaultClear;
    ce && wr && hit(busReq.addr, `STATUS_ADDR) && busReq.wdata[`FAULT_FLAG_BIT];
  endsequence

  AST_UPPER_ZERO: assert property (busRsp.ack |-> busRsp.rdata[15:8] == 8'h00)
    else $error("upper data lane not zero");
  AST_ACK_NEXT: assert property (ce && busReq.sel |=> busRsp.ack)
    else $error("bus access not answered");
  AST_RDATA_IDLE: assert property (!busRsp.ack |-> busRsp.rdata == 16'h0000)
    else $error("read data not cleared");
  AST_EVEN_ZERO: assert property (ce && rd && (busReq.addr[0] == 1'b0)
    |=> busRsp.rdata == 16'h0000)
    else $error("even address read not zero");
  AST_SECOND_DIR: assert property (sSecondDirWrite
    |=> secondPortLinesOe == $past(busReq.wdata[7:0]))
    else $error("direction did not reach enables");
  AST_FIRST_DIR: assert property (ce && wr && hit(busReq.addr, `FIRST_DIR_ADDR)
    |=> firstPortLinesOe == $past(busReq.wdata[7:0]))
    else $error("first direction did not reach enables");
  AST_SECOND_OUT: assert property (ce && wr && hit(busReq.addr, `SECOND_DATA_ADDR)
    |=> secondPortLinesOut == $past(busReq.wdata[7:0]))
    else $error("second data did not reach lines");
  AST_READY: assert property (ce |=> printerReady == ($past(secondPortLinesIn[0])
    && !$past(secondPortLinesIn[1]) && !$past(secondPortLinesIn[2])))
    else $error("printer ready wrong");
  AST_INIT_LOW: assert property (ce && secondEn && secondCtrl_q[`LEVEL_BIT]
    && !genCtrl_q[`INIT_SENSE_BIT] |=> !printerResetN)
    else $error("initialise line not low");
  AST_INIT_OFF: assert property (ce && !secondEn && !genCtrl_q[`INIT_SENSE_BIT]
    |=> printerResetN)
    else $error("initialise line active while pair disabled");
  AST_STATUS_LEVELS: assert property (sStatusRead |=> busRsp.rdata[7:4]
    == $past({printerResetN, faultInLine, dataOutStrobe, ackInStrobe}))
    else $error("status levels wrong");
  AST_FAULT_SET_WINS: assert property (ce && faultEvent |=> faultFlag_q)
    else $error("fault edge lost");
  AST_FAULT_CLEAR: assert property (sFaultClear ##0 !faultEvent |=> !faultFlag_q)
    else $error("fault flag not cleared");
  AST_STROBE_PIN: assert property (ce && firstEn && strobeOn
    && !genCtrl_q[`STROBE_SENSE_BIT] |=> !dataOutStrobe)
    else $error("strobe pin not asserted");
  AST_STROBE_OFF: assert property (ce && !firstEn && !genCtrl_q[`STROBE_SENSE_BIT]
    |=> dataOutStrobe)
    else $error("strobe pin active while pair disabled");
endmodule // printer_parallel_port
`default_nettype wire

// file: core/printer_port_params.svh
// Constants for the printer parallel port
// Overview of operation
// - Eight-bit output port with first handshake pair, eight-bit two-way port with second.
// - First pair output line strobes valid output data to the printer.
// - Lowest three second-port lines carry select, paper out, busy; high means asserted.
// - Printer not ready when paper out, busy, or not selected.
// - Second pair output drives printer initialise; low clears and initialises the printer.
// - Byte-wide registers on low data lanes at odd addresses from the base.
// - General control holds mode, two pair enables and four line sense bits.
// - Direction bit one makes a line output; first port outputs, second inputs.
// - Port control holds submode, handshake control, and bit 3 sets output level.
// - Sending writes the code to first port data, then strobes the printer.
// - Next byte waits for acknowledge; status bit 0 shows a free output latch.
// - Status shows four line levels high nibble, three flags low, bit 3 reads zero.
`ifndef PRINTER_PORT_PARAMS_SVH
`define PRINTER_PORT_PARAMS_SVH

`define GEN_CTRL_ADDR 24'h01_0001
`define SVC_REQ_ADDR 24'h01_0003
`define FIRST_DIR_ADDR 24'h01_0005
`define SECOND_DIR_ADDR 24'h01_0007
`define FIRST_CTRL_ADDR 24'h01_000D
`define SECOND_CTRL_ADDR 24'h01_000F
`define FIRST_DATA_ADDR 24'h01_0011
`define SECOND_DATA_ADDR 24'h01_0013
`define STATUS_ADDR 24'h01_001B

`define REG_RESET 8'h00
`define PIN_IDLE 1'b1

`define MODE_HI 7
`define MODE_LO 6
`define SECOND_EN_BIT 5
`define FIRST_EN_BIT 4
`define INIT_SENSE_BIT 3
`define FAULT_SENSE_BIT 2
`define STROBE_SENSE_BIT 1
`define ACK_SENSE_BIT 0
`define LEVEL_BIT 3

`define FAULT_FLAG_BIT 2
`define EMPTY_FLAG_BIT 1
`define READY_FLAG_BIT 0

`define SELECT_BIT 0
`define PAPER_OUT_BIT 1
`define BUSY_BIT 2

`define CLK_MHZ 40
`define STROBE_TIME_NS 1000
`define STROBE_CYCLES ((`STROBE_TIME_NS * `CLK_MHZ + 999) / 1000)
`define STROBE_CNT_W 6

`endif

// file: core/printer_port_pkg.sv
// Types shared by the printer parallel port
package printer_port_pkg;
  typedef struct packed {
    logic sel;
    logic write;
    logic [23:0] addr;
    logic [15:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } bus_rsp_t;

  typedef enum logic [1:0] {LATCH_IDLE, LATCH_SETUP, LATCH_STROBE, LATCH_WAIT} latch_state_t;
endpackage

// file: core/output_latch.sv
// Double output latch with strobe and acknowledge sequencing
`timescale 1ns/1ps
`default_nettype none
`include "printer_port_params.svh"
module output_latch (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  // Load side
  input wire logic loadValid,
  input wire logic [7:0] loadData,
  // Printer side
  input wire logic ackEvent,
  output logic [7:0] lineData,
  output logic strobeOn,
  // Status
  output logic canAccept,
  output logic bothEmpty
);
  import printer_port_pkg::*;

  latch_state_t state_q, state_d;
  logic [7:0] front_q, front_d;
  logic frontFull_q, frontFull_d;
  logic [7:0] lineData_q, lineData_d;
  logic strobeOn_q, strobeOn_d;
  logic ackSeen_q, ackSeen_d;
  logic [`STROBE_CNT_W-1:0] count_q, count_d;
  logic canAccept_q, canAccept_d;
  logic bothEmpty_q, bothEmpty_d;
  logic xfer;
  logic accept;

  // ==========================================
  // Next state
  always_comb
  begin
    state_d = state_q;
    lineData_d = lineData_q;
    strobeOn_d = strobeOn_q;
    ackSeen_d = ackSeen_q;
    count_d = count_q;
    xfer = frontFull_q && (state_q == LATCH_IDLE);
    accept = loadValid && (!frontFull_q || xfer);
    front_d = accept ? loadData : front_q;
    frontFull_d = (frontFull_q && !xfer) || accept;
    case (state_q)
      LATCH_IDLE:
      begin
        if (xfer)
        begin
          lineData_d = front_q;
          state_d = LATCH_SETUP;
        end
      end
      LATCH_SETUP:
      begin
        if (enable)
        begin
          strobeOn_d = 1'b1;
          ackSeen_d = 1'b0;
          count_d = `STROBE_CNT_W'(`STROBE_CYCLES);
          state_d = LATCH_STROBE;
        end
      end
      LATCH_STROBE:
      begin
        if (ackEvent)
        begin
          ackSeen_d = 1'b1;
        end
        if (count_q == `STROBE_CNT_W'(1))
        begin
          strobeOn_d = 1'b0;
          state_d = (ackSeen_q || ackEvent) ? LATCH_IDLE : LATCH_WAIT;
        end
        else
        begin
          count_d = count_q - `STROBE_CNT_W'(1);
        end
      end
      LATCH_WAIT:
      begin
        if (ackEvent)
        begin
          state_d = LATCH_IDLE;
        end
      end
      default:
      begin
        state_d = LATCH_IDLE;
      end
    endcase
    canAccept_d = !(frontFull_d && (state_d != LATCH_IDLE));
    bothEmpty_d = !frontFull_d && (state_d == LATCH_IDLE);
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= LATCH_IDLE;
      front_q <= `REG_RESET;
      frontFull_q <= 1'b0;
      lineData_q <= `REG_RESET;
      strobeOn_q <= 1'b0;
      ackSeen_q <= 1'b0;
      count_q <= '0;
      canAccept_q <= 1'b1;
      bothEmpty_q <= 1'b1;
    end
    else if (ce)
    begin
      state_q <= state_d;
      front_q <= front_d;
      frontFull_q <= frontFull_d;
      lineData_q <= lineData_d;
      strobeOn_q <= strobeOn_d;
      ackSeen_q <= ackSeen_d;
      count_q <= count_d;
      canAccept_q <= canAccept_d;
      bothEmpty_q <= bothEmpty_d;
    end
  end

  assign lineData = lineData_q;
  assign strobeOn = strobeOn_q;
  assign canAccept = canAccept_q;
  assign bothEmpty = bothEmpty_q;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence sSetupReady;
    ce && (state_q == LATCH_SETUP) && enable;
  endsequence

  AST_SETUP_THEN_STROBE: assert property (sSetupReady |=> strobeOn_q && $stable(lineData_q))
    else $error("strobe did not follow stable data");
  AST_NO_OVERWRITE: assert property (ce && loadValid && frontFull_q
    && (state_q != LATCH_IDLE) |=> $stable(front_q))
    else $error("full latch overwritten");
  AST_STROBE_HOLD: assert property ($rose(strobeOn_q) |-> strobeOn_q [*8])
    else $error("strobe too short");
  AST_FREE_FLAG: assert property (canAccept_q == !(frontFull_q && (state_q != LATCH_IDLE)))
    else $error("free latch flag wrong");
  AST_ACK_RELEASES: assert property (ce && (state_q == LATCH_WAIT) && ackEvent
    |=> state_q == LATCH_IDLE)
    else $error("acknowledge did not free latch");
endmodule // output_latch
`default_nettype wire

// file: verif/printer_model.sv
// Printer model: strobe capture, acknowledge, status and fault lines
`timescale 1ns/1ps
`default_nettype none
module printer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Printer link
  input wire logic [7:0] dataLines,
  input wire logic strobeN,
  input wire logic initN,
  output logic ackN,
  output logic faultN,
  output logic [7:0] statusLines,
  // Bench control
  input wire logic [7:0] ackDelay,
  input wire logic [2:0] condSet,
  input wire logic faultReq,
  output logic [7:0] lastByte,
  output logic [7:0] rxCount
);
  logic strobeQ;
  logic pending;
  logic [7:0] waitCnt;
  logic [4:0] junk;
  // ==========================================
  // Status and fault lines
  // status high means asserted, fault low means asserted; unused lines toggle
  assign statusLines = {junk, condSet};
  assign faultN = !faultReq;
  // ==========================================
  // Capture and acknowledge
  always @(posedge clk)
  begin
    junk <= ~junk;
    strobeQ <= strobeN;
    ackN <= 1'b1;
    if (rst || !initN)
    begin
      rxCount <= 8'h00;
      pending <= 1'b0;
      strobeQ <= 1'b1;
      junk <= 5'h0A;
    end
    else if (strobeQ && !strobeN)
    begin
      lastByte <= dataLines;
      rxCount <= rxCount + 8'h01;
      pending <= 1'b1;
      waitCnt <= ackDelay;
    end
    else if (pending)
    begin
      if (waitCnt == 8'h00)
      begin
        ackN <= 1'b0;
        pending <= 1'b0;
      end
      waitCnt <= waitCnt - 8'h01;
    end
  end
endmodule // printer_model
`default_nettype wire

// file: verif/tb_top.sv
// Testbench for the printer parallel port
`timescale 1ns/1ps
`default_nettype none
`include "printer_port_params.svh"
module tb_top;
  import printer_port_pkg::*;
  logic clk, rst, ce, ackN, faultN, initN, strobeN, faultReq, ready;
  bus_req_t busReq;
  bus_rsp_t busRsp;
  logic [7:0] lines, linesOe, secIn, secOut, secOe, ackDelay, lastByte, rxCount, rd, run, lastRun;
  logic [2:0] condSet;
  int num_errors, checks_done;
  printer_parallel_port u_printer_parallel_port (.clk(clk), .rst(rst), .ce(ce),
    .busReq(busReq), .busRsp(busRsp), .firstPortLines(lines), .firstPortLinesOe(linesOe),
    .dataOutStrobe(strobeN), .ackInStrobe(ackN), .secondPortLinesIn(secIn),
    .secondPortLinesOut(secOut), .secondPortLinesOe(secOe), .faultInLine(faultN),
    .printerResetN(initN), .printerReady(ready));
  printer_model u_printer_model (.clk(clk), .rst(rst), .dataLines(lines), .strobeN(strobeN),
    .initN(initN), .ackN(ackN), .faultN(faultN), .statusLines(secIn), .ackDelay(ackDelay),
    .condSet(condSet), .faultReq(faultReq), .lastByte(lastByte), .rxCount(rxCount));
  // ==========================================
  // Clock and strobe width monitor
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (rst) run <= 8'h00;
    else if (!strobeN) run <= run + 8'h01;
    else if (run != 8'h00)
    begin
      lastRun <= run;
      run <= 8'h00;
    end
  end
  // ==========================================
  // Helpers
  task automatic end_of_test;
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic timeout(input string msg);
    num_errors++;
    $display("CHECK FAILED at %0t: %s timed out", $time, msg);
    end_of_test();
  endtask
  task automatic bus(input logic wr, input logic [23:0] addr, input logic [7:0] wd);
    int n;
    @(posedge clk);
    #2;
    busReq = '{1'b1, wr, addr, {8'h00, wd}};
    @(posedge clk);
    #2;
    busReq.sel = 1'b0;
    n = 0;
    while (busRsp.ack !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #2;
      n++;
    end
    if (busRsp.ack !== 1'b1) timeout("bus answer");
    rd = busRsp.rdata[7:0];
    check8(busRsp.rdata[15:8], 8'h00, "upper lane");
  endtask
  task automatic rdChk(input logic [23:0] addr, input logic [7:0] exp, input string msg);
    bus(1'b0, addr, 8'h00);
    check8(rd, exp, msg);
  endtask
  task automatic waitStatus(input logic [7:0] mask);
    int n;
    n = 0;
    bus(1'b0, `STATUS_ADDR, 8'h00);
    while ((rd & mask) !== mask && n < 500)
    begin
      bus(1'b0, `STATUS_ADDR, 8'h00);
      n++;
    end
    if ((rd & mask) !== mask) timeout("status wait");
  endtask
  // mask to seven bits, period for controls below 20h except CR and LF
  function automatic logic [7:0] filt(input logic [7:0] c);
    logic [7:0] m;
    m = c & 8'h7F;
    if (m < 8'h20 && m != 8'h0D && m != 8'h0A) m = 8'h2E;
    return m;
  endfunction
  // ==========================================
  // Scenarios
  task automatic testReset;
    logic [23:0] regs [8];
    regs = '{`GEN_CTRL_ADDR, `SVC_REQ_ADDR, `FIRST_DIR_ADDR, `SECOND_DIR_ADDR,
      `FIRST_CTRL_ADDR, `SECOND_CTRL_ADDR, `FIRST_DATA_ADDR, 24'h01_0009};
    foreach (regs[i]) rdChk(regs[i], 8'h00, "reset value");
    rdChk(24'h01_0010, 8'h00, "even address");
    rdChk(`STATUS_ADDR, 8'hF3, "idle status");
    check8({7'h00, strobeN}, 8'h01, "strobe idle");
    check8({7'h00, initN}, 8'h01, "init idle");
  endtask
  task automatic testInit;
    bus(1'b1, `GEN_CTRL_ADDR, 8'h00);
    bus(1'b1, `GEN_CTRL_ADDR, 8'h30);
    bus(1'b1, `SVC_REQ_ADDR, 8'h00);
    bus(1'b1, `FIRST_DIR_ADDR, 8'hFF);
    bus(1'b1, `SECOND_DIR_ADDR, 8'h00);
    bus(1'b1, `FIRST_CTRL_ADDR, 8'h60);
    bus(1'b1, `SECOND_CTRL_ADDR, 8'hA0);
    rdChk(`GEN_CTRL_ADDR, 8'h30, "general control");
    rdChk(`FIRST_CTRL_ADDR, 8'h60, "first control");
    rdChk(`SECOND_CTRL_ADDR, 8'hA0, "second control");
    check8(linesOe, 8'hFF, "first outputs");
    check8(secOe, 8'h00, "second inputs");
    bus(1'b1, `SECOND_DATA_ADDR, 8'h5A);
    check8(secOut, 8'h5A, "second data out");
    bus(1'b1, `FIRST_CTRL_ADDR, 8'h68);
    @(posedge clk);
    #2;
    check8({7'h00, strobeN}, 8'h00, "strobe level set");
    bus(1'b1, `FIRST_CTRL_ADDR, 8'h60);
    @(posedge clk);
    #2;
    check8({7'h00, strobeN}, 8'h01, "strobe level clear");
    bus(1'b1, `SECOND_CTRL_ADDR, 8'hA8);
    @(posedge clk);
    #2;
    check8({7'h00, initN}, 8'h00, "init pulse low");
    bus(1'b1, `SECOND_CTRL_ADDR, 8'hA0);
    @(posedge clk);
    #2;
    check8({7'h00, initN}, 8'h01, "init released");
  endtask
  task automatic testSend;
    logic [7:0] chars [7];
    logic [7:0] base;
    int n;
    chars = '{8'h41, 8'h8D, 8'h0A, 8'h05, 8'hFF, 8'h20, 8'h1F};
    foreach (chars[i])
    begin
      base = rxCount;
      bus(1'b1, `FIRST_DATA_ADDR, filt(chars[i]));
      n = 0;
      while (rxCount == base && n < 300)
      begin
        @(posedge clk);
        #2;
        n++;
      end
      if (rxCount == base) timeout("strobe");
      check8(lastByte, filt(chars[i]), "printed byte");
      waitStatus(8'h02);
      repeat (2) @(posedge clk);
      #2;
      check8(lastRun, 8'(`STROBE_CYCLES), "strobe width");
    end
  endtask
  task automatic testFull;
    logic [7:0] base;
    ackDelay = 8'hC8;
    base = rxCount;
    bus(1'b1, `FIRST_DATA_ADDR, 8'h31);
    bus(1'b1, `FIRST_DATA_ADDR, 8'h32);
    bus(1'b1, `FIRST_DATA_ADDR, 8'h33);
    rdChk(`STATUS_ADDR, 8'hD0, "both latches full");
    check8(lines, 8'h31, "data held");
    waitStatus(8'h02);
    check8(rxCount, base + 8'h02, "third dropped");
    check8(lastByte, 8'h32, "second byte");
    ackDelay = 8'h03;
  endtask
  task automatic testReady;
    for (int i = 0; i < 8; i++)
    begin
      condSet = i[2:0];
      repeat (3) @(posedge clk);
      #2;
      check8({7'h00, ready}, {7'h00, i == 1}, "printer ready");
      bus(1'b0, `SECOND_DATA_ADDR, 8'h00);
      check8(rd & 8'h07, {5'h00, i[2:0]}, "status lines");
    end
    condSet = 3'b101;
    bus(1'b1, `FIRST_DATA_ADDR, 8'h52);
    waitStatus(8'h02);
    bus(1'b0, `SECOND_DATA_ADDR, 8'h00);
    check8(rd & 8'h07, 8'h05, "busy after strobe");
    condSet = 3'b001;
    repeat (3) @(posedge clk);
    #2;
    check8({7'h00, ready}, 8'h01, "ready again");
    bus(1'b1, `FIRST_DATA_ADDR, 8'h52);
    waitStatus(8'h02);
    check8(lastByte, 8'h52, "resent byte");
  endtask
  task automatic testFault;
    faultReq = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    faultReq = 1'b0;
    rdChk(`STATUS_ADDR, 8'hF7, "fault flag");
    bus(1'b1, `STATUS_ADDR, 8'h04);
    rdChk(`STATUS_ADDR, 8'hF3, "fault cleared");
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    num_errors = 0;
    checks_done = 0;
    rst = 1'b1;
    ce = 1'b1;
    busReq = '0;
    ackDelay = 8'h03;
    condSet = 3'b001;
    faultReq = 1'b0;
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    testReset();
    testInit();
    testSend();
    testFull();
    testReady();
    testFault();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
